// ---- hw/pdm_consts.vh ----
// constants for the powered-device mode sequencer
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH
`define PDM_CLK_HZ 50000000
`define PDM_NOISE_NS 100000
`define PDM_CLASS_MAX 3'h4
`define PDM_CLASS_W 3
`define PDM_CNT_W 16
`define PDM_CNT_ZERO 16'h0000
`define PDM_CNT_ONE 16'h0001
`define PDM_ADDR_CTRL 4'h0
`define PDM_ADDR_STAT 4'h4
`define PDM_CTRL_RST 32'h00000004
`define PDM_EV_CLASS2 3'h3
`endif

// ---- hw/pdm_sync.v ----
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module pdm_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire resetn,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ---- hw/pdm_filt.v ----
// level filter: accepts a change only after it stays stable
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_filt #(
    parameter [`PDM_CNT_W-1:0] STABLE = 16'h1389
) (
    input wire sys_clk,
    input wire resetn,
    input wire din,
    output reg dout
);
    reg [`PDM_CNT_W-1:0] cnt_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= `PDM_CNT_ZERO;
            dout <= 1'b0;
        end else if (din == dout) begin
            cnt_q <= `PDM_CNT_ZERO;
        end else if (cnt_q >= STABLE) begin
            // RL20 stable long enough
            dout <= din;
            cnt_q <= `PDM_CNT_ZERO;
        end else begin
            cnt_q <= cnt_q + `PDM_CNT_ONE;
        end
    end
endmodule

// ---- hw/pdm_seq.v ----
// Summary of operation
// RL1 - sourcing end probes twice, 1V apart, inside 2.7V to 10.1V window.
// RL2 - two-event classification recognised drives the source-type flag high.
// RL3 - single classification event keeps flag low, source treated Type 1.
// RL4 - pulses up to 100us during classification are rejected.
// RL5 - Type 1 source classifies holding 14.5V to 20.5V and measuring current.
// RL6 - class 4 setting needed for Type 2 recognition.
// RL7 - class current select follows the programmed class selection.
// RL8 - class current is switched off once classification ends.
// RL9 - class, mark, class, mark, class sequence answered event by event.
// RL10 - idle after classification, waiting for the on threshold.
// RL11 - reaching the turn-on threshold enters on, full power to converter.
// RL12 - local-power sense has hysteresis between high and low thresholds.
// RL13 - local power opens line hot-swap switch, converter keeps running.
// RL14 - local power wins over line power whatever the voltages.
// RL15 - local power removed returns to line power if present.
// RL16 - supply below 2.7V enters reset, power off, back to pre-detection.
// RL17 - modes run reset, detection, classification, idle, on in order.
// RL18 - flag stays high until reset or power-down.
// RL19 - local-power sense forces the flag high always.
// RL20 - filter accepts class or mark change only after stable period.
// RL21 - comparator and sense levels synchronised before use.
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_seq #(
    parameter NOISE_CYC = ((`PDM_NOISE_NS / 1000) * (`PDM_CLK_HZ / 1000000)) + 1
) (
    input wire sys_clk,
    input wire resetn,
    input wire above_reset_lvl,
    input wire above_detect_lvl,
    input wire in_class_band,
    input wire in_mark_band,
    input wire above_on_lvl,
    input wire lp_above_high,
    input wire lp_above_low,
    input wire [2:0] class_set_resistor_pin,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg type2_source_flag,
    output reg local_power_sense,
    output reg class_current_en,
    output reg [2:0] class_current_sel,
    output reg detect_sig_en,
    output reg switched_line_supply_out,
    output reg converter_en,
    output reg [4:0] mode
);
    localparam [4:0] ST_RESET = 5'h01;
    localparam [4:0] ST_DET = 5'h02;
    localparam [4:0] ST_CLASS = 5'h04;
    localparam [4:0] ST_IDLE = 5'h08;
    localparam [4:0] ST_ON = 5'h10;

    wire [6:0] sync_out;
    wire rst_ok, det_ok, cls_raw, mark_raw, on_ok, lp_hi, lp_lo;
    wire cls_f, mark_f;
    reg [4:0] state_q, state_d;
    reg [2:0] ev_q, ev_d;
    reg cls_prev_q, flag_q, flag_d, soft_rst_q;
    reg [2:0] class_cfg_q;
    wire [2:0] cls_pin_s;

    // RL21 sync comparators
    pdm_sync #(.W(7)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din({above_reset_lvl, above_detect_lvl, in_class_band, in_mark_band, above_on_lvl,
              lp_above_high, lp_above_low}),
        .dout(sync_out)
    );
    assign {rst_ok, det_ok, cls_raw, mark_raw, on_ok, lp_hi, lp_lo} = sync_out;

    // RL21 sync class pin
    pdm_sync #(.W(3)) u_sync_cls (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(class_set_resistor_pin),
        .dout(cls_pin_s)
    );

    // RL4 filter class band
    pdm_filt #(.STABLE(NOISE_CYC[`PDM_CNT_W-1:0])) u_fcls (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(cls_raw),
        .dout(cls_f)
    );
    // RL4 filter mark band
    pdm_filt #(.STABLE(NOISE_CYC[`PDM_CNT_W-1:0])) u_fmark (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(mark_raw),
        .dout(mark_f)
    );

    function is_reg;
        input [3:0] a;
        input [3:0] off;
        begin
            is_reg = (a == off);
        end
    endfunction

    // RL12 hysteresis on sense
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            local_power_sense <= 1'b0;
        end else if (lp_hi) begin
            local_power_sense <= 1'b1;
        end else if (!lp_lo) begin
            local_power_sense <= 1'b0;
        end
    end

    always @* begin
        state_d = state_q;
        ev_d = ev_q;
        flag_d = flag_q;
        case (state_q)
            ST_RESET: begin
                ev_d = 3'h0;
                flag_d = 1'b0;
                // RL17 leave reset
                if (rst_ok) begin
                    state_d = ST_DET;
                end
            end
            ST_DET: begin
                if (det_ok) begin
                    state_d = ST_CLASS;
                end
            end
            ST_CLASS: begin
                // RL9 count class entries
                if (cls_f && !cls_prev_q && ev_q != 3'h7) begin
                    ev_d = ev_q + 3'h1;
                end
                if (on_ok) begin
                    state_d = ST_IDLE;
                end else if (!cls_f && !mark_f && !det_ok) begin
                    state_d = ST_DET;
                end
                // RL2 two-event seen
                if (ev_q >= 3'h2 || (cls_f && !cls_prev_q && ev_q == 3'h1)) begin
                    flag_d = 1'b1;
                end
            end
            ST_IDLE: begin
                // RL11 turn on
                if (on_ok) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (!on_ok && !det_ok) begin
                    state_d = ST_DET;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        // RL16 undervoltage reset
        if (!rst_ok || soft_rst_q) begin
            state_d = ST_RESET;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_RESET;
            ev_q <= 3'h0;
            flag_q <= 1'b0;
            cls_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ev_q <= ev_d;
            // RL18 sticky flag
            flag_q <= flag_d;
            cls_prev_q <= cls_f;
        end
    end

    // outputs registered
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            type2_source_flag <= 1'b0;
            class_current_en <= 1'b0;
            class_current_sel <= 3'h0;
            detect_sig_en <= 1'b0;
            switched_line_supply_out <= 1'b0;
            converter_en <= 1'b0;
            mode <= ST_RESET;
        end else begin
            mode <= state_d;
            // RL19 RL3 flag with override
            type2_source_flag <= flag_d | local_power_sense;
            detect_sig_en <= (state_d == ST_DET);
            // RL8 RL10 class current only in class
            class_current_en <= (state_d == ST_CLASS) && (cls_f || ev_d == 3'h0);
            // RL7 RL6 selected class
            class_current_sel <= class_cfg_q;
            // RL13 RL14 RL15 local power priority
            switched_line_supply_out <= (state_d == ST_ON) && !local_power_sense;
            converter_en <= (state_d == ST_ON) || local_power_sense;
        end
    end

    // class select: pin setting, capped at class 4, software may override
    reg ovr_q;
    reg [2:0] ovr_cls_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            class_cfg_q <= 3'h0;
        end else if (ovr_q) begin
            class_cfg_q <= ovr_cls_q;
        end else if (cls_pin_s > `PDM_CLASS_MAX) begin
            class_cfg_q <= `PDM_CLASS_MAX;
        end else begin
            class_cfg_q <= cls_pin_s;
        end
    end

    // one wait state on reads, so registered data stands when waitrequest drops
    reg rd_wait_q;
    assign avs_waitrequest = avs_read && !rd_wait_q;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_wait_q <= 1'b0;
            ovr_q <= 1'b0;
            ovr_cls_q <= 3'h0;
            soft_rst_q <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_wait_q <= avs_read && !rd_wait_q;
            if (avs_write && is_reg(avs_address, `PDM_ADDR_CTRL) && avs_byteenable[0]) begin
                ovr_cls_q <= (avs_writedata[2:0] > `PDM_CLASS_MAX) ? `PDM_CLASS_MAX : avs_writedata[2:0];
                ovr_q <= avs_writedata[3];
                soft_rst_q <= avs_writedata[4];
            end
            if (avs_read && !rd_wait_q) begin
                if (is_reg(avs_address, `PDM_ADDR_CTRL)) begin
                    avs_readdata <= {27'h0, soft_rst_q, ovr_q, ovr_cls_q};
                end else if (is_reg(avs_address, `PDM_ADDR_STAT)) begin
                    avs_readdata <= {16'h0, 1'b0, class_cfg_q, ev_q, local_power_sense,
                                     type2_source_flag, 2'h0, state_q};
                end else begin
                    avs_readdata <= 32'h00000000;
                end
            end
        end
    end
endmodule

// ---- test/pdm_pse.sv ----
// cable-side sourcing equipment model
`timescale 1ns/1ns
module pdm_pse (
    input wire logic sys_clk,
    input wire logic [2:0] step,
    output logic above_reset_lvl,
    output logic above_detect_lvl,
    output logic in_class_band,
    output logic in_mark_band,
    output logic above_on_lvl
);
    initial {above_reset_lvl, above_detect_lvl, in_class_band, in_mark_band, above_on_lvl} = 5'h00;
    always @(posedge sys_clk) begin
        above_reset_lvl <= step != 3'h0;
        above_detect_lvl <= step > 3'h1;
        in_class_band <= step == 3'h2;
        in_mark_band <= step == 3'h3;
        above_on_lvl <= step == 3'h4;
    end
endmodule

// ---- test/pdm_seq_sva.sv ----
// assertion checker for the mode sequencer
`timescale 1ns/1ns
module pdm_seq_sva #(
    parameter NOISE_CYC = 4
) (
    input wire sys_clk,
    input wire resetn,
    input wire lp_above_high,
    input wire lp_above_low,
    input wire type2_source_flag,
    input wire local_power_sense,
    input wire class_current_en,
    input wire [2:0] class_current_sel,
    input wire switched_line_supply_out,
    input wire converter_en,
    input wire [4:0] mode
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_lp_held;
        local_power_sense ##1 local_power_sense;
    endsequence
    a_mode_onehot:
    assert property ($onehot(mode)) else $error("mode not one-hot");
    a_mode_order:
    assert property ($changed(mode) |-> mode == 5'h01 || mode == 5'h02 || mode == ($past(mode) << 1))
        else $error("mode step out of order");
    a_reset_off:
    assert property (mode == 5'h01 |-> !converter_en && !switched_line_supply_out) else $error("power in reset");
    a_class_cur_off:
    assert property (class_current_en |-> mode == 5'h04 || $past(mode) == 5'h04) else $error("class current late");
    a_class_sel:
    assert property (class_current_en |-> class_current_sel <= 3'h4) else $error("class select range");
    a_lp_opens:
    assert property (s_lp_held |-> !switched_line_supply_out && converter_en) else $error("line switch closed");
    a_lp_flag:
    assert property (s_lp_held |-> type2_source_flag) else $error("flag not forced");
    a_lp_rise:
    assert property ($rose(local_power_sense) |-> $past(lp_above_high, 2) || $past(lp_above_high, 3)
        || $past(lp_above_high, 4)) else $error("sense rose without high");
    a_lp_fall:
    assert property ($fell(local_power_sense) |-> !$past(lp_above_low, 2) || !$past(lp_above_low, 3)
        || !$past(lp_above_low, 4)) else $error("sense fell above low");
    a_flag_hold:
    assert property ($fell(type2_source_flag) |-> mode == 5'h01 || $past(local_power_sense)
        || $past(local_power_sense, 2)) else $error("flag dropped");
    a_flag_rise:
    assert property ($rose(type2_source_flag) |-> mode == 5'h04 || $past(mode) == 5'h04 || lp_above_high)
        else $error("flag rose outside class");
endmodule
bind pdm_seq pdm_seq_sva #(.NOISE_CYC(NOISE_CYC)) u_sva (.sys_clk(sys_clk), .resetn(resetn),
    .lp_above_high(lp_above_high), .lp_above_low(lp_above_low), .type2_source_flag(type2_source_flag),
    .local_power_sense(local_power_sense), .class_current_en(class_current_en),
    .class_current_sel(class_current_sel), .switched_line_supply_out(switched_line_supply_out),
    .converter_en(converter_en), .mode(mode));

// ---- test/testbench.sv ----
// self-checking bench for the mode sequencer
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] step = 3'h0;
    logic lp_above_high = 1'b0;
    logic lp_above_low = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    wire above_reset_lvl, above_detect_lvl, in_class_band, in_mark_band, above_on_lvl, avs_waitrequest;
    wire type2_source_flag, local_power_sense, class_current_en, detect_sig_en, switched_line_supply_out;
    wire converter_en;
    wire [2:0] class_current_sel;
    wire [4:0] mode;
    wire [31:0] avs_readdata;
    int err_total = 0;
    int samples_checked = 0;
    always #10 sys_clk = ~sys_clk;
    pdm_pse pse (.sys_clk, .step, .above_reset_lvl, .above_detect_lvl, .in_class_band, .in_mark_band,
        .above_on_lvl);
    // small filter count keeps the run short
    pdm_seq #(.NOISE_CYC(4)) dut (.sys_clk, .resetn, .above_reset_lvl, .above_detect_lvl, .in_class_band,
        .in_mark_band, .above_on_lvl, .lp_above_high, .lp_above_low, .class_set_resistor_pin(3'h4),
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .type2_source_flag, .local_power_sense, .class_current_en, .class_current_sel,
        .detect_sig_en, .switched_line_supply_out, .converter_en, .mode);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [2:0] s, input int n);
        @(posedge sys_clk);
        step <= s;
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic t_type1();
        go(3'h1, 20);
        go(3'h2, 30);
        chk(mode, 5'h04);
        chk({class_current_en, class_current_sel}, 4'hC);
        go(3'h4, 20);
        chk(mode, 5'h10);
        chk({type2_source_flag, class_current_en}, 2'h0);
        chk({converter_en, switched_line_supply_out}, 2'h3);
    endtask
    task automatic t_local();
        @(posedge sys_clk);
        lp_above_high <= 1'b1;
        lp_above_low <= 1'b1;
        go(3'h4, 10);
        chk({local_power_sense, type2_source_flag}, 2'h3);
        chk({switched_line_supply_out, converter_en}, 2'h1);
        @(posedge sys_clk);
        lp_above_high <= 1'b0;
        go(3'h4, 10);
        chk(local_power_sense, 1'b1);
        @(posedge sys_clk);
        lp_above_low <= 1'b0;
        go(3'h4, 10);
        chk({local_power_sense, switched_line_supply_out}, 2'h1);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        bus(1'b0, 4'h4, 32'h0, d);
        chk(d[7:0], 8'h10);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, d);
        bus(1'b0, 4'h0, 32'h0, d);
        chk(d, 32'h0);
        bus(1'b0, 4'h8, 32'h0, d);
        chk(d, 32'h0);
    endtask
    task automatic t_type2();
        go(3'h0, 10);
        chk({mode, type2_source_flag, converter_en}, 7'h04);
        go(3'h1, 20);
        chk({mode, detect_sig_en}, 6'h05);
        for (int i = 0; i < 5; i++) go((i % 2) ? 3'h3 : 3'h2, 30);
        chk(type2_source_flag, 1'b1);
        go(3'h4, 20);
        chk(type2_source_flag, 1'b1);
        go(3'h0, 10);
        chk(type2_source_flag, 1'b0);
    endtask
    task automatic t_noise();
        go(3'h1, 20);
        go(3'h2, 30);
        go(3'h3, 30);
        // glitch shorter than the filter count
        go(3'h2, 3);
        go(3'h3, 30);
        go(3'h4, 20);
        chk({mode, type2_source_flag}, 6'h20);
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_type1();
        t_local();
        t_regs();
        t_type2();
        t_noise();
        finish_test();
    end
endmodule
